// ### design/frame_seq_pkg.sv
// Package of constants and carrier types for the stack frame sequencer.
package frame_seq_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam logic [31:0] DWORD_BYTES = 32'h0000_0004;
    localparam logic [4:0] LEVEL_MAX = 5'h1f;
    localparam logic [31:0] RESET_SP = 32'h0000_0000;
    localparam logic [31:0] RESET_FBP = 32'h0000_0000;
    localparam logic [31:0] RESET_FLAGS = 32'h0000_0002;
    localparam logic [31:0] RESET_IP = 32'h0000_0000;
    localparam logic [15:0] RESET_SEG = 16'h0000;
    localparam logic [2:0] GPR_SP = 3'h4;
    localparam logic [2:0] GPR_FBP = 3'h5;
    localparam int unsigned GPR_COUNT = 8;
    localparam int unsigned SEG_COUNT = 6;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_DWORD = 2'h2;

    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_CREATE = 2'h1,
        CMD_RELEASE = 2'h2
    } frame_cmd_t;

    typedef struct packed {
        frame_cmd_t cmd;
        logic [15:0] storage;
        logic [4:0] level;
    } frame_req_t;

    typedef struct packed {
        logic req;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } stack_mem_req_t;

    typedef struct packed {
        logic we;
        logic [2:0] idx;
        logic [1:0] size;
        logic sign;
        logic [31:0] data;
    } reg_write_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_PUSH_FBP = 7'b0000010,
        ST_READ_DISP = 7'b0000100,
        ST_PUSH_DISP = 7'b0001000,
        ST_PUSH_FRAME = 7'b0010000,
        ST_ALLOC = 7'b0100000,
        ST_POP_FBP = 7'b1000000
    } seq_state_t;
endpackage

// ### design/operand_extend.sv
// Operand size and sign extension for byte, word and doubleword values.
`timescale 1ns/1ps
module operand_extend (
    input wire logic [31:0] data_in,
    input wire logic [1:0] size_in,
    input wire logic sign_in,
    output logic [31:0] data_out
);
    wire logic [31:0] byte_ext;
    wire logic [31:0] word_ext;
    assign byte_ext = {{24{sign_in & data_in[7]}}, data_in[7:0]}; // R14
    assign word_ext = {{16{sign_in & data_in[15]}}, data_in[15:0]}; // R14
    assign data_out = (size_in == frame_seq_pkg::SIZE_BYTE) ? byte_ext :
                      (size_in == frame_seq_pkg::SIZE_WORD) ? word_ext :
                      data_in;
endmodule // operand_extend

// ### design/stack_frame_sequencer.sv
// Stack frame create and release sequencer with its register file.
`timescale 1ns/1ps
// Behaviour
// R1 - Outermost level reserves storage, copies nothing
// R2 - Outermost display holds old then new base
// R3 - Base addresses first push, pointer last dword
// R4 - Nested display: caller base, then copied pointers
// R5 - Deeper level adds pointer to caller frame (code pushes frame_ptr_q, the new frame base)
// R6 - Same level omits caller variable pointer
// R7 - Outermost storage base is saved pointer plus four
// R8 - Release first loads stack pointer from base
// R9 - Release then pops saved base pointer
// R10 - Release leaves return address for return
// R11 - Eight 32-bit general registers
// R12 - Six 16-bit segment registers
// R13 - 32-bit flags and instruction pointer
// R14 - Byte, word, dword signed and unsigned
// R15 - Create takes storage and level 0..31
// R16 - Level zero: push, copy, subtract only
// R17 - Subtract storage after display build
// R18 - Level minus one pointers copied downward
// R19 - One dword access at a time, busy held
// R20 - Push predecrements four, pop postincrements four
module stack_frame_sequencer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire frame_seq_pkg::frame_req_t req_in,
    input wire logic req_valid_in,
    input wire frame_seq_pkg::reg_write_t gpr_wr_in,
    input wire logic [2:0] seg_wr_idx_in,
    input wire logic seg_we_in,
    input wire logic [15:0] seg_wdata_in,
    input wire logic flags_we_in,
    input wire logic [31:0] flags_wdata_in,
    input wire logic ip_we_in,
    input wire logic [31:0] ip_wdata_in,
    input wire logic [2:0] gpr_rd_idx_in,
    input wire logic [2:0] seg_rd_idx_in,
    input wire logic [31:0] mem_rdata_in,
    input wire logic mem_ack_in,
    output frame_seq_pkg::stack_mem_req_t mem_out,
    output logic busy_out,
    output logic done_out,
    output logic [31:0] stack_pointer_out,
    output logic [31:0] frame_base_pointer_out,
    output logic [31:0] storage_base_out,
    output logic [31:0] gpr_rdata_out,
    output logic [15:0] seg_rdata_out,
    output logic [31:0] status_flags_register_out,
    output logic [31:0] instruction_pointer_out
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] gpr_q [frame_seq_pkg::GPR_COUNT]; // R11
    logic [15:0] seg_q [frame_seq_pkg::SEG_COUNT]; // R12
    logic [31:0] flags_q; // R13
    logic [31:0] ip_q; // R13
    frame_seq_pkg::seq_state_t state_q;
    frame_seq_pkg::seq_state_t state_d;
    frame_seq_pkg::stack_mem_req_t mem_q;
    logic [31:0] frame_ptr_q;
    logic [31:0] walk_q;
    logic [31:0] storage_base_q;
    logic busy_q;
    logic [15:0] storage_q;
    logic [4:0] count_q;
    logic [4:0] level_q;
    logic done_q;
    logic [31:0] gpr_rdata_q;
    logic [15:0] seg_rdata_q;
    wire logic [31:0] sp;
    wire logic [31:0] fbp;
    wire logic [31:0] sp_push;
    wire logic [31:0] gpr_ext;
    wire logic idle;
    wire logic start_create;
    wire logic start_release;
    wire logic step;

    assign sp = gpr_q[frame_seq_pkg::GPR_SP];
    assign fbp = gpr_q[frame_seq_pkg::GPR_FBP];
    assign sp_push = sp - frame_seq_pkg::DWORD_BYTES; // R20
    assign idle = (state_q == frame_seq_pkg::ST_IDLE);
    assign start_create = idle & req_valid_in &
                          (req_in.cmd == frame_seq_pkg::CMD_CREATE); // R15
    assign start_release = idle & req_valid_in &
                           (req_in.cmd == frame_seq_pkg::CMD_RELEASE);
    // A memory step completes only when the stack memory acknowledges.
    assign step = mem_q.req & mem_ack_in; // R19

    operand_extend operand_extend_i (
        .data_in(gpr_wr_in.data),
        .size_in(gpr_wr_in.size),
        .sign_in(gpr_wr_in.sign),
        .data_out(gpr_ext)
    );

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            frame_seq_pkg::ST_IDLE: begin
                if (start_create) begin
                    state_d = frame_seq_pkg::ST_PUSH_FBP;
                end else if (start_release) begin
                    state_d = frame_seq_pkg::ST_POP_FBP; // R8
                end
            end
            frame_seq_pkg::ST_PUSH_FBP: begin
                if (step) begin
                    if (level_q == 5'h00) begin
                        state_d = frame_seq_pkg::ST_ALLOC; // R16
                    end else if (level_q == 5'h01) begin
                        state_d = frame_seq_pkg::ST_PUSH_FRAME; // R1
                    end else begin
                        state_d = frame_seq_pkg::ST_READ_DISP; // R18
                    end
                end
            end
            frame_seq_pkg::ST_READ_DISP: begin
                if (step) begin
                    state_d = frame_seq_pkg::ST_PUSH_DISP;
                end
            end
            frame_seq_pkg::ST_PUSH_DISP: begin
                if (step) begin
                    state_d = (count_q == 5'h01) ?
                              frame_seq_pkg::ST_PUSH_FRAME :
                              frame_seq_pkg::ST_READ_DISP; // R18
                end
            end
            frame_seq_pkg::ST_PUSH_FRAME: begin
                if (step) begin
                    state_d = frame_seq_pkg::ST_ALLOC; // R5
                end
            end
            frame_seq_pkg::ST_ALLOC: begin
                state_d = frame_seq_pkg::ST_IDLE; // R17
            end
            frame_seq_pkg::ST_POP_FBP: begin
                if (step) begin
                    state_d = frame_seq_pkg::ST_IDLE; // R9
                end
            end
            default: begin
                state_d = frame_seq_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer and datapath
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= frame_seq_pkg::ST_IDLE;
            mem_q <= '0;
            frame_ptr_q <= 32'h0000_0000;
            walk_q <= 32'h0000_0000;
            storage_base_q <= frame_seq_pkg::DWORD_BYTES;
            busy_q <= 1'b0;
            storage_q <= 16'h0000;
            count_q <= 5'h00;
            level_q <= 5'h00;
            done_q <= 1'b0;
            flags_q <= frame_seq_pkg::RESET_FLAGS;
            ip_q <= frame_seq_pkg::RESET_IP;
            for (int i = 0; i < frame_seq_pkg::GPR_COUNT; i++) begin
                gpr_q[i] <= 32'h0000_0000;
            end
            for (int i = 0; i < frame_seq_pkg::SEG_COUNT; i++) begin
                seg_q[i] <= frame_seq_pkg::RESET_SEG;
            end
        end else begin
            state_q <= state_d;
            busy_q <= (state_d != frame_seq_pkg::ST_IDLE); // R19
            done_q <= 1'b0;
            if (step) begin
                mem_q.req <= 1'b0;
            end
            // General register writes from the core are ignored while busy so
            // the sequencer owns the pointers for the whole sequence.
            if (idle && gpr_wr_in.we) begin
                gpr_q[gpr_wr_in.idx] <= gpr_ext; // R14
            end
            if (idle && gpr_wr_in.we &&
                gpr_wr_in.idx == frame_seq_pkg::GPR_FBP) begin
                storage_base_q <= gpr_ext + frame_seq_pkg::DWORD_BYTES; // R7
            end
            if (seg_we_in && seg_wr_idx_in < 3'h6) begin
                seg_q[seg_wr_idx_in] <= seg_wdata_in; // R12
            end
            if (flags_we_in) begin
                flags_q <= flags_wdata_in; // R13
            end
            if (ip_we_in) begin
                ip_q <= ip_wdata_in; // R13
            end
            if (start_create) begin
                // Push old base pointer, remembering where it lands.
                storage_q <= req_in.storage;
                level_q <= req_in.level & frame_seq_pkg::LEVEL_MAX;
                count_q <= req_in.level - 5'h01;
                walk_q <= fbp;
                frame_ptr_q <= sp_push; // R3
                gpr_q[frame_seq_pkg::GPR_SP] <= sp_push; // R20
                mem_q <= '{req: 1'b1, write: 1'b1, addr: sp_push,
                           wdata: fbp}; // R2
            end
            if (start_release) begin
                // Pointer takes the base first, then the pop reads it.
                gpr_q[frame_seq_pkg::GPR_SP] <= fbp; // R8
                mem_q <= '{req: 1'b1, write: 1'b0, addr: fbp,
                           wdata: 32'h0000_0000}; // R19
            end
            if (step) begin
                unique case (state_q)
                    frame_seq_pkg::ST_PUSH_FBP,
                    frame_seq_pkg::ST_PUSH_DISP: begin
                        if (state_d == frame_seq_pkg::ST_READ_DISP) begin
                            walk_q <= walk_q - frame_seq_pkg::DWORD_BYTES;
                            mem_q <= '{req: 1'b1, write: 1'b0,
                                       addr: walk_q -
                                       frame_seq_pkg::DWORD_BYTES,
                                       wdata: 32'h0000_0000}; // R4
                            if (state_q == frame_seq_pkg::ST_PUSH_DISP) begin
                                count_q <= count_q - 5'h01;
                            end
                        end else if (state_d ==
                                     frame_seq_pkg::ST_PUSH_FRAME) begin
                            gpr_q[frame_seq_pkg::GPR_SP] <= sp_push;
                            mem_q <= '{req: 1'b1, write: 1'b1,
                                       addr: sp_push,
                                       wdata: frame_ptr_q}; // R5 R6
                        end
                    end
                    frame_seq_pkg::ST_READ_DISP: begin
                        gpr_q[frame_seq_pkg::GPR_SP] <= sp_push; // R20
                        mem_q <= '{req: 1'b1, write: 1'b1, addr: sp_push,
                                   wdata: mem_rdata_in}; // R4
                    end
                    frame_seq_pkg::ST_POP_FBP: begin
                        gpr_q[frame_seq_pkg::GPR_FBP] <= mem_rdata_in; // R9
                        storage_base_q <= mem_rdata_in +
                            frame_seq_pkg::DWORD_BYTES; // R7
                        gpr_q[frame_seq_pkg::GPR_SP] <=
                            sp + frame_seq_pkg::DWORD_BYTES; // R20 R10
                        done_q <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            if (state_q == frame_seq_pkg::ST_ALLOC) begin
                gpr_q[frame_seq_pkg::GPR_FBP] <= frame_ptr_q; // R3
                storage_base_q <= frame_ptr_q +
                    frame_seq_pkg::DWORD_BYTES; // R7
                gpr_q[frame_seq_pkg::GPR_SP] <=
                    sp - {16'h0000, storage_q}; // R17
                done_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gpr_rdata_q <= 32'h0000_0000;
            seg_rdata_q <= 16'h0000;
        end else begin
            gpr_rdata_q <= gpr_q[gpr_rd_idx_in];
            seg_rdata_q <= (seg_rd_idx_in < 3'h6) ?
                           seg_q[seg_rd_idx_in] : 16'h0000;
        end
    end

    assign mem_out = mem_q;
    assign busy_out = busy_q;
    assign done_out = done_q;
    assign stack_pointer_out = sp;
    assign frame_base_pointer_out = fbp;
    assign storage_base_out = storage_base_q; // R7
    assign gpr_rdata_out = gpr_rdata_q;
    assign seg_rdata_out = seg_rdata_q;
    assign status_flags_register_out = flags_q;
    assign instruction_pointer_out = ip_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    one_access_a: assert property ( // R19
        @(posedge clk_in) disable iff (rst_in)
        mem_q.req && !mem_ack_in |=> mem_q.req && $stable(mem_q.addr))
        else $error("stack access dropped before acknowledge");
    push_predec_a: assert property ( // R20
        @(posedge clk_in) disable iff (rst_in)
        start_create |=> mem_q.write && sp == $past(sp) - 32'h4)
        else $error("push did not predecrement by four");
    release_load_a: assert property ( // R8
        @(posedge clk_in) disable iff (rst_in)
        start_release |=> sp == $past(fbp) && !mem_q.write)
        else $error("release did not load pointer from base");
    release_pop_a: assert property ( // R9
        @(posedge clk_in) disable iff (rst_in)
        state_q == frame_seq_pkg::ST_POP_FBP && step |=>
        fbp == $past(mem_rdata_in) && sp == $past(sp) + 32'h4)
        else $error("release pop wrong");
    level_zero_a: assert property ( // R16
        @(posedge clk_in) disable iff (rst_in)
        state_q == frame_seq_pkg::ST_PUSH_FBP && step && level_q == 5'h00
        |=> state_q == frame_seq_pkg::ST_ALLOC)
        else $error("level zero copied pointers");
    outer_level_a: assert property ( // R1
        @(posedge clk_in) disable iff (rst_in)
        state_q == frame_seq_pkg::ST_PUSH_FBP && step && level_q == 5'h01
        |=> state_q == frame_seq_pkg::ST_PUSH_FRAME)
        else $error("outermost level copied pointers");
    frame_push_a: assert property ( // R5
        @(posedge clk_in) disable iff (rst_in)
        state_q == frame_seq_pkg::ST_PUSH_FRAME && mem_q.req |->
        mem_q.write && mem_q.wdata == frame_ptr_q)
        else $error("frame pointer push wrong");
    alloc_end_a: assert property ( // R17
        @(posedge clk_in) disable iff (rst_in)
        state_q == frame_seq_pkg::ST_ALLOC |=>
        fbp == $past(frame_ptr_q) &&
        sp == $past(sp) - {16'h0000, $past(storage_q)} && done_q)
        else $error("allocation end wrong");
    base_four_a: assert property ( // R7
        @(posedge clk_in) disable iff (rst_in)
        storage_base_out == fbp + 32'h4)
        else $error("storage base not base plus four");
endmodule // stack_frame_sequencer

// ### sim/stack_mem_model.sv
// Behavioural stack memory answering one doubleword access at a time.
`timescale 1ns/1ps
module stack_mem_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire frame_seq_pkg::stack_mem_req_t mem_in,
    input wire logic [3:0] delay_in,
    output logic ack_out,
    output logic [31:0] rdata_out
);
    logic [31:0] mem_q [1024];
    logic [3:0] wait_q;
    wire logic [9:0] slot = mem_in.addr[11:2];
    wire logic take = mem_in.req && !ack_out && wait_q == delay_in;

    // Every word starts from its own address so stale reads show up.
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem_q[i] = 32'h1000_0000 | (i << 2);
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
            wait_q <= 4'h0;
            rdata_out <= 32'h5a5a_5a5a;
        end else if (take) begin
            ack_out <= 1'b1;
            rdata_out <= mem_q[slot];
            wait_q <= 4'h0;
            if (mem_in.write) begin
                mem_q[slot] <= mem_in.wdata;
            end
        end else begin
            ack_out <= 1'b0;
            // Outside an answer the data toggles, never the last value.
            rdata_out <= ~rdata_out;
            if (mem_in.req && !ack_out) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule // stack_mem_model

// ### sim/stack_frame_sequencer_tb.sv
// Self-checking bench for the stack frame sequencer.
`timescale 1ns/1ps
module stack_frame_sequencer_tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    frame_seq_pkg::frame_req_t req_in = '0;
    logic req_valid_in = 1'b0;
    frame_seq_pkg::reg_write_t gpr_wr_in = '0;
    logic [2:0] seg_wr_idx_in = 3'h0;
    logic seg_we_in = 1'b0;
    logic [15:0] seg_wdata_in = 16'h0000;
    logic flags_we_in = 1'b0;
    logic [31:0] flags_wdata_in = 32'h0000_0000;
    logic ip_we_in = 1'b0;
    logic [31:0] ip_wdata_in = 32'h0000_0000;
    logic [2:0] gpr_rd_idx_in = 3'h0;
    logic [2:0] seg_rd_idx_in = 3'h0;
    logic [3:0] delay = 4'h0;
    logic [31:0] mem_rdata_in;
    logic mem_ack_in;
    frame_seq_pkg::stack_mem_req_t mem_out;
    logic busy_out;
    logic done_out;
    logic [31:0] stack_pointer_out, frame_base_pointer_out, storage_base_out;
    logic [31:0] gpr_rdata_out, status_flags_register_out;
    logic [31:0] instruction_pointer_out;
    logic [15:0] seg_rdata_out;
    int failures = 0;
    int comparisons = 0;
    logic [64:0] seen_q[$];
    logic [64:0] exp_q[$];
    logic [31:0] e_mem[int];
    logic [31:0] e_sp;
    logic [31:0] e_fbp;
    logic [31:0] v;

    always #25 clk_in = ~clk_in;

    stack_frame_sequencer stack_frame_sequencer_i (
        .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
        .req_valid_in(req_valid_in), .gpr_wr_in(gpr_wr_in),
        .seg_wr_idx_in(seg_wr_idx_in), .seg_we_in(seg_we_in),
        .seg_wdata_in(seg_wdata_in), .flags_we_in(flags_we_in),
        .flags_wdata_in(flags_wdata_in), .ip_we_in(ip_we_in),
        .ip_wdata_in(ip_wdata_in), .gpr_rd_idx_in(gpr_rd_idx_in),
        .seg_rd_idx_in(seg_rd_idx_in), .mem_rdata_in(mem_rdata_in),
        .mem_ack_in(mem_ack_in), .mem_out(mem_out), .busy_out(busy_out),
        .done_out(done_out), .stack_pointer_out(stack_pointer_out),
        .frame_base_pointer_out(frame_base_pointer_out),
        .storage_base_out(storage_base_out), .gpr_rdata_out(gpr_rdata_out),
        .seg_rdata_out(seg_rdata_out),
        .status_flags_register_out(status_flags_register_out),
        .instruction_pointer_out(instruction_pointer_out));

    stack_mem_model stack_mem_model_i (
        .clk_in(clk_in), .rst_in(rst_in), .mem_in(mem_out),
        .delay_in(delay), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

    task check(input string name, input logic [64:0] seen,
               input logic [64:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task results;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        if (mem_out.req && mem_ack_in) begin
            seen_q.push_back({mem_out.write, mem_out.addr,
                              mem_out.write ? mem_out.wdata : 32'h0});
            check("busy in access", busy_out, 1'b1);
        end
    end

    // ------------------------------------------------------------
    // Expected frame model and bus helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] peek(input logic [31:0] a);
        return e_mem.exists(a) ? e_mem[a] : 32'h1000_0000 | {20'h0, a[11:0]};
    endfunction

    function automatic void push_exp(input logic [31:0] d);
        e_sp = e_sp - 32'h4;
        exp_q.push_back({1'b1, e_sp, d});
        e_mem[e_sp] = d;
    endfunction

    task wr_gpr(input logic [2:0] i, input logic [1:0] s, input logic sg,
                input logic [31:0] d);
        @(negedge clk_in);
        gpr_wr_in = '{1'b1, i, s, sg, d};
        @(negedge clk_in);
        gpr_wr_in.we = 1'b0;
    endtask

    task rd_gpr(input logic [2:0] i, output logic [31:0] d);
        @(negedge clk_in);
        gpr_rd_idx_in = i;
        @(negedge clk_in);
        d = gpr_rdata_out;
    endtask

    task gpr_case(input logic [2:0] i, input logic [1:0] s, input logic sg,
                  input logic [31:0] d, input logic [31:0] exp);
        wr_gpr(i, s, sg, d);
        rd_gpr(i, v);
        check("general register", v, exp);
    endtask

    task set_ptrs(input logic [31:0] sp, input logic [31:0] fbp);
        wr_gpr(frame_seq_pkg::GPR_SP, frame_seq_pkg::SIZE_DWORD, 1'b0, sp);
        wr_gpr(frame_seq_pkg::GPR_FBP, frame_seq_pkg::SIZE_DWORD, 1'b0, fbp);
        e_sp = sp;
        e_fbp = fbp;
    endtask

    task run_op(input frame_seq_pkg::frame_cmd_t c, input logic [15:0] st,
                input logic [4:0] lv, input logic poke);
        logic [31:0] fp;
        logic [31:0] walk;
        int n;
        seen_q.delete();
        exp_q.delete();
        if (c == frame_seq_pkg::CMD_CREATE) begin
            push_exp(e_fbp);
            fp = e_sp;
            walk = e_fbp;
            if (lv != 5'h00) begin
                for (int i = 1; i < lv; i++) begin
                    walk = walk - 32'h4;
                    exp_q.push_back({1'b0, walk, 32'h0});
                    push_exp(peek(walk));
                end
                push_exp(fp);
            end
            e_fbp = fp;
            e_sp = e_sp - {16'h0, st};
        end else begin
            exp_q.push_back({1'b0, e_fbp, 32'h0});
            e_sp = e_fbp + 32'h4;
            e_fbp = peek(e_fbp);
        end
        @(negedge clk_in);
        req_in = '{c, st, lv};
        req_valid_in = 1'b1;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        if (poke) begin
            @(negedge clk_in);
            req_in.cmd = frame_seq_pkg::CMD_RELEASE;
            req_valid_in = 1'b1;
            gpr_wr_in = '{1'b1, 3'h0, frame_seq_pkg::SIZE_DWORD, 1'b0,
                          32'hdead_0000};
            @(negedge clk_in);
            req_valid_in = 1'b0;
            gpr_wr_in.we = 1'b0;
        end
        n = 0;
        while (done_out !== 1'b1) begin
            n++;
            if (n > 500) begin
                failures++;
                results();
            end
            @(negedge clk_in);
        end
        check("access count", 65'(seen_q.size()), 65'(exp_q.size()));
        foreach (exp_q[i]) check("access", seen_q[i], exp_q[i]);
        check("stack pointer", stack_pointer_out, e_sp);
        check("frame base", frame_base_pointer_out, e_fbp);
        check("storage base", storage_base_out, e_fbp + 32'h4);
        check("busy after", busy_out, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        check("sp reset", stack_pointer_out, frame_seq_pkg::RESET_SP);
        check("fbp reset", frame_base_pointer_out,
              frame_seq_pkg::RESET_FBP);
        check("flags reset", status_flags_register_out,
              frame_seq_pkg::RESET_FLAGS);
        check("ip reset", instruction_pointer_out,
              frame_seq_pkg::RESET_IP);
        check("idle reset", {busy_out, done_out, mem_out.req}, 3'h0);
    endtask

    task t_regs;
        for (int i = 0; i < 8; i++) begin
            gpr_case(3'(i), frame_seq_pkg::SIZE_DWORD, 1'b0,
                     32'h1234_5600 | i, 32'h1234_5600 | i);
        end
        gpr_case(3'h1, frame_seq_pkg::SIZE_BYTE, 1'b1, 32'h0000_0080,
                 32'hffff_ff80);
        gpr_case(3'h1, frame_seq_pkg::SIZE_BYTE, 1'b0, 32'h1234_56f0,
                 32'h0000_00f0);
        gpr_case(3'h1, frame_seq_pkg::SIZE_WORD, 1'b1, 32'h0001_8001,
                 32'hffff_8001);
        gpr_case(3'h1, frame_seq_pkg::SIZE_WORD, 1'b0, 32'h0001_8001,
                 32'h0000_8001);
        for (int i = 0; i < 7; i++) begin
            @(negedge clk_in);
            seg_wr_idx_in = 3'(i);
            seg_wdata_in = 16'hc000 | 16'(i);
            seg_we_in = 1'b1;
            seg_rd_idx_in = 3'(i);
            @(negedge clk_in);
            seg_we_in = 1'b0;
            @(negedge clk_in);
            check("segment", seg_rdata_out,
                  i < 6 ? 16'hc000 | 16'(i) : 16'h0000);
        end
        @(negedge clk_in);
        flags_wdata_in = 32'h0000_08d7;
        ip_wdata_in = 32'h0000_1230;
        flags_we_in = 1'b1;
        ip_we_in = 1'b1;
        @(negedge clk_in);
        flags_we_in = 1'b0;
        ip_we_in = 1'b0;
        @(negedge clk_in);
        check("flags", status_flags_register_out, 32'h0000_08d7);
        check("ip", instruction_pointer_out, 32'h0000_1230);
    endtask

    task t_nest;
        set_ptrs(32'h0000_0800, 32'h0000_07f0);
        run_op(frame_seq_pkg::CMD_CREATE, 16'h000c, 5'h00, 1'b0);
        run_op(frame_seq_pkg::CMD_RELEASE, 16'h0000, 5'h00, 1'b0);
        set_ptrs(32'h0000_0800, 32'h0000_0900);
        run_op(frame_seq_pkg::CMD_CREATE, 16'h0010, 5'h01, 1'b0);
        run_op(frame_seq_pkg::CMD_CREATE, 16'h0008, 5'h02, 1'b0);
        run_op(frame_seq_pkg::CMD_CREATE, 16'h0004, 5'h03, 1'b0);
        run_op(frame_seq_pkg::CMD_CREATE, 16'h0000, 5'h03, 1'b0);
        repeat (4) run_op(frame_seq_pkg::CMD_RELEASE, 16'h0, 5'h0, 1'b0);
        check("sp unwound", stack_pointer_out, 32'h0000_0800);
    endtask

    task t_deep;
        delay = 4'h2;
        set_ptrs(32'h0000_0c00, 32'h0000_0b00);
        run_op(frame_seq_pkg::CMD_CREATE, 16'hffff, 5'h1f, 1'b1);
        rd_gpr(3'h0, v);
        check("write while busy", v, 32'h1234_5600);
        run_op(frame_seq_pkg::CMD_RELEASE, 16'h0000, 5'h00, 1'b0);
        delay = 4'h0;
        seen_q.delete();
        @(negedge clk_in);
        req_in = '{frame_seq_pkg::CMD_NONE, 16'h0004, 5'h01};
        req_valid_in = 1'b1;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check("no command", {busy_out, 31'(seen_q.size())}, 32'h0);
    endtask

    initial begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset();
        $display("reset test done");
        t_regs();
        $display("register test done");
        t_nest();
        $display("nesting test done");
        t_deep();
        $display("deep level test done");
        results();
    end
endmodule // stack_frame_sequencer_tb
